// *** common/mtc_consts.svh ***
// constants for the modem turnaround control block
`ifndef MTC_CONSTS_SVH
`define MTC_CONSTS_SVH
// timing
`define MTC_CLK_HZ     40000000
`define MTC_IGN_MS     250
`define MTC_IGN_CYC    ((`MTC_CLK_HZ / 1000) * `MTC_IGN_MS)
`define MTC_REP_PER_S  22
`define MTC_REP_CYC    (`MTC_CLK_HZ / `MTC_REP_PER_S)
`define MTC_IGN_W      24
`define MTC_REP_W      21
// received control codes
`define MTC_CODE_ETX   8'h03
`define MTC_CODE_EOT   8'h04
`define MTC_CODE_CTRLN 8'h0e
`define MTC_CODE_CTRLO 8'h0f
// data path
`define MTC_DATA_W     8
`define MTC_FIFO_D     8
`endif

// *** common/mtc_pkg.sv ***
// types of the modem turnaround control block
`include "mtc_consts.svh"
package mtc_pkg;
  typedef enum logic [2:0] {
    MTC_MODE_OFF, MTC_MODE_DIRECT, MTC_MODE_FDX, MTC_MODE_CODE, MTC_MODE_SEC, MTC_MODE_IDLE
  } mtc_mode_e;
  typedef logic [`MTC_DATA_W-1:0] mtc_byte_t;
  typedef struct packed {
    logic [2:0]            cts_sy;
    logic [2:0]            dcd_sy;
    logic [2:0]            sec_sy;
    logic [2:0]            xrts_sy;
    logic [2:0]            brk_sy;
    logic                  cts_q;
    logic                  dcd_q;
    logic                  sec_q;
    logic                  xrts_q;
    logic                  brk_q;
    logic                  dcd_prev;
    logic                  rts;
    logic [`MTC_IGN_W-1:0] ign_cnt;
    logic                  gate_on;
    logic                  kb_lock;
    logic                  pend;
    mtc_byte_t             pend_data;
    logic                  sending;
    logic                  busy_d;
    logic                  tx_start;
    mtc_byte_t             tx_data;
    logic                  force_space;
    logic [`MTC_REP_W-1:0] rep_cnt;
    logic                  echo_valid;
    mtc_byte_t             echo_data;
  } mtc_state_s;
endpackage : mtc_pkg

// *** src/mtc_turnaround.sv ***
// modem turnaround control with extension port buffer
//
// How it works
// - received bytes are always decoded, never held off by transmit handshake
// - rts announces intent to send; no character starts while cts is low
// - extension port peripheral may drive rts instead of own logic
// - no connection mode selected keeps rts low
// - direct connect raises rts before each character, drops it when sent
// - full duplex modem holds rts high
// - half duplex modem uses code or secondary turnaround, one direction
// - secondary mode: half duplex, method secondary, both code enables off
// - secondary mode raises rts on sec receive high and carrier fall
// - secondary receive low with carrier high clears rts unless the extension port drives it
// - secondary transmit line raised to let the host send
// - every rts change starts a 250 ms window ignoring received codes
// - code mode: half duplex, method code, at least one code enable on
// - code mode raises rts when carrier falls after turnaround code
// - turnaround code seen again drops rts; a character due in that same cycle still starts
// - received data is forwarded to extension port unless gated off
// - gated position: ctrl-o disables, ctrl-n enables forwarding
// - break key forces transmit data to spacing
// - every key transmits; half duplex echoes locally
// - held key repeats at 22 per second, limited by transmit rate
// - keyboard lock position: codes lock and unlock keyboard instead
`timescale 1ns/10ps
`include "mtc_consts.svh"

module mtc_fifo #(
  parameter int WIDTH = `MTC_DATA_W,
  parameter int DEPTH = `MTC_FIFO_D
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst,
  // filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0]                 wr;
    logic [AW:0]                 rd;
  } mtc_fifo_s;
  mtc_fifo_s st_r, st_nxt;
  logic full, empty;

  // full and empty from pointers with wrap bit
  assign empty     = (st_r.wr == st_r.rd);
  assign full      = (st_r.wr[AW-1:0] == st_r.rd[AW-1:0]) && (st_r.wr[AW] != st_r.rd[AW]);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = st_r.mem[st_r.rd[AW-1:0]];

  // pointer and storage update
  always_comb begin
    st_nxt = st_r;
    if (in_valid && !full) begin
      st_nxt.mem[st_r.wr[AW-1:0]] = in_data;
      st_nxt.wr = st_r.wr + 1'b1;
    end
    if (out_ready && !empty) begin
      st_nxt.rd = st_r.rd + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule : mtc_fifo

module mtc_turnaround import mtc_pkg::*; #(
  parameter int IGNORE_CYCLES = `MTC_IGN_CYC,
  parameter int REPEAT_CYCLES = `MTC_REP_CYC
) (
  // clock and reset
  input  wire logic      ref_clk,
  input  wire logic      rst,
  // configuration switches
  input  wire logic      half_duplex_modem_select,
  input  wire logic      full_duplex_modem_select,
  input  wire logic      direct_connect_select,
  input  wire logic      turnaround_method_select,
  input  wire logic      eot_turnaround_enable,
  input  wire logic      etx_turnaround_enable,
  input  wire logic      extension_gate_select,
  input  wire logic      ext_rts_select,
  input  wire logic      fdx_mode,
  // modem and extension pins
  input  wire logic      cts_pin,
  input  wire logic      dcd_pin,
  input  wire logic      sec_rcve_pin,
  input  wire logic      ext_rts_pin,
  output logic           rts_out,
  output logic           sec_xmit_out,
  output logic           txd_force_space,
  // keyboard
  input  wire logic      break_key,
  input  wire logic      repeat_key,
  input  wire logic      key_valid,
  output logic           key_ready,
  input  wire mtc_byte_t key_data,
  output logic           keyboard_locked,
  output logic           echo_valid,
  output mtc_byte_t      echo_data,
  // transmit serializer
  output logic           tx_start,
  output mtc_byte_t      tx_data,
  input  wire logic      tx_busy,
  // receive deserializer
  input  wire logic      rx_valid,
  output logic           rx_ready,
  input  wire mtc_byte_t rx_data,
  output logic           cmd_ignoring,
  // extension port output stream
  output logic           ext_valid,
  input  wire logic      ext_ready,
  output mtc_byte_t      ext_data,
  output logic           ext_enabled
);
  mtc_state_s st_r, st_nxt;
  mtc_mode_e  mode;
  logic       ignoring, fifo_in_ready, fwd_valid, rx_take, cmd_ok, is_turn_code;
  logic       dcd_fall, rts_want, tx_done;

  localparam logic [`MTC_IGN_W-1:0] IGN_LOAD = IGNORE_CYCLES[`MTC_IGN_W-1:0];
  localparam logic [`MTC_REP_W-1:0] REP_LOAD = REPEAT_CYCLES[`MTC_REP_W-1:0];

  // connection mode from the switches
  always_comb begin
    if (half_duplex_modem_select) begin
      if (turnaround_method_select && (eot_turnaround_enable || etx_turnaround_enable)) begin
        mode = MTC_MODE_CODE;
      end else if (!turnaround_method_select && !eot_turnaround_enable && !etx_turnaround_enable) begin
        mode = MTC_MODE_SEC;
      end else begin
        mode = MTC_MODE_IDLE;
      end
    end else if (full_duplex_modem_select) begin
      mode = MTC_MODE_FDX;
    end else if (direct_connect_select) begin
      mode = MTC_MODE_DIRECT;
    end else begin
      mode = MTC_MODE_OFF;
    end
  end

  // receive side decode
  assign ignoring     = (st_r.ign_cnt != '0);
  assign rx_take      = rx_valid && rx_ready;
  assign cmd_ok       = rx_take && !ignoring;
  assign is_turn_code = (eot_turnaround_enable && rx_data == `MTC_CODE_EOT) ||
                        (etx_turnaround_enable && rx_data == `MTC_CODE_ETX);
  assign fwd_valid    = rx_valid && st_r.gate_on;
  assign rx_ready     = st_r.gate_on ? fifo_in_ready : 1'b1;
  assign dcd_fall     = st_r.dcd_prev && !st_r.dcd_q;
  assign tx_done      = st_r.busy_d && !tx_busy;

  // next state
  always_comb begin
    st_nxt = st_r;
    // three stage pin synchronisers, change taken when stages two and three agree
    st_nxt.cts_sy  = {st_r.cts_sy[1:0], cts_pin};
    st_nxt.dcd_sy  = {st_r.dcd_sy[1:0], dcd_pin};
    st_nxt.sec_sy  = {st_r.sec_sy[1:0], sec_rcve_pin};
    st_nxt.xrts_sy = {st_r.xrts_sy[1:0], ext_rts_pin};
    st_nxt.brk_sy  = {st_r.brk_sy[1:0], break_key};
    if (st_r.cts_sy[1] == st_r.cts_sy[2]) st_nxt.cts_q = st_r.cts_sy[2];
    if (st_r.dcd_sy[1] == st_r.dcd_sy[2]) st_nxt.dcd_q = st_r.dcd_sy[2];
    if (st_r.sec_sy[1] == st_r.sec_sy[2]) st_nxt.sec_q = st_r.sec_sy[2];
    if (st_r.xrts_sy[1] == st_r.xrts_sy[2]) st_nxt.xrts_q = st_r.xrts_sy[2];
    if (st_r.brk_sy[1] == st_r.brk_sy[2]) st_nxt.brk_q = st_r.brk_sy[2];
    st_nxt.dcd_prev    = st_r.dcd_q;
    st_nxt.busy_d      = tx_busy;
    st_nxt.force_space = st_r.brk_q;
    st_nxt.tx_start    = 1'b0;
    st_nxt.echo_valid  = 1'b0;

    // rts per mode
    rts_want = st_r.rts;
    unique case (mode)
      MTC_MODE_OFF:    rts_want = 1'b0;
      MTC_MODE_FDX:    rts_want = 1'b1;
      MTC_MODE_IDLE:   rts_want = 1'b0;
      MTC_MODE_DIRECT: begin
        if (st_r.pend && !st_r.sending) rts_want = 1'b1;
        else if (st_r.sending && tx_done && !st_r.pend) rts_want = 1'b0;
      end
      MTC_MODE_CODE: begin
        if (st_r.rts && cmd_ok && is_turn_code) rts_want = 1'b0;
        else if (!st_r.rts && dcd_fall) rts_want = 1'b1;
      end
      MTC_MODE_SEC: begin
        if (!st_r.sec_q && st_r.dcd_q) rts_want = 1'b0;
        else if (st_r.sec_q && dcd_fall) rts_want = 1'b1;
      end
    endcase
    if (ext_rts_select) rts_want = st_r.xrts_q;
    st_nxt.rts = rts_want;

    // ignore window restarts on every rts edge
    if (rts_want != st_r.rts) st_nxt.ign_cnt = IGN_LOAD;
    else if (ignoring) st_nxt.ign_cnt = st_r.ign_cnt - 1'b1;

    // extension gating or keyboard lock by remote codes
    if (cmd_ok && rx_data == `MTC_CODE_CTRLO) begin
      if (extension_gate_select) st_nxt.gate_on = 1'b0;
      else st_nxt.kb_lock = 1'b1;
    end else if (cmd_ok && rx_data == `MTC_CODE_CTRLN) begin
      if (extension_gate_select) st_nxt.gate_on = 1'b1;
      else st_nxt.kb_lock = 1'b0;
    end
    if (!extension_gate_select) st_nxt.gate_on = 1'b1;

    // key capture and auto repeat
    if (st_r.rep_cnt != '0) st_nxt.rep_cnt = st_r.rep_cnt - 1'b1;
    if (key_valid && key_ready) begin
      st_nxt.pend      = 1'b1;
      st_nxt.pend_data = key_data;
      st_nxt.rep_cnt   = REP_LOAD;
    end else if (repeat_key && !st_r.pend && !st_r.sending && st_r.rep_cnt == '0 && !st_r.kb_lock) begin
      st_nxt.pend    = 1'b1;
      st_nxt.rep_cnt = REP_LOAD;
    end

    // transmit completion
    if (tx_done) st_nxt.sending = 1'b0;

    // start a character only with rts up, cts up and no break
    if (st_r.pend && st_r.rts && st_r.cts_q && !st_r.brk_q && !st_r.sending && !tx_busy &&
        !(mode == MTC_MODE_SEC && !rts_want)) begin
      st_nxt.tx_start   = 1'b1;
      st_nxt.tx_data    = st_r.pend_data;
      st_nxt.pend       = 1'b0;
      st_nxt.sending    = 1'b1;
      st_nxt.echo_valid = !fdx_mode;
      st_nxt.echo_data  = st_r.pend_data;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_r         <= '0;
      st_r.gate_on <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs
  assign key_ready       = !st_r.pend && !st_r.kb_lock;
  assign rts_out         = st_r.rts;
  assign sec_xmit_out    = (mode == MTC_MODE_SEC) && !st_r.rts;
  assign txd_force_space = st_r.force_space;
  assign keyboard_locked = st_r.kb_lock;
  assign echo_valid      = st_r.echo_valid;
  assign echo_data       = st_r.echo_data;
  assign tx_start        = st_r.tx_start;
  assign tx_data         = st_r.tx_data;
  assign cmd_ignoring    = ignoring;
  assign ext_enabled     = st_r.gate_on;

  // extension port buffer
  mtc_fifo #(.WIDTH(`MTC_DATA_W), .DEPTH(`MTC_FIFO_D)) u_ext_fifo (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .in_valid  (fwd_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (rx_data),
    .out_valid (ext_valid),
    .out_ready (ext_ready),
    .out_data  (ext_data)
  );

  // checks
  sequence s_rts_edge;
    $changed(rts_out);
  endsequence
  sequence s_start_ok;
    rts_out && st_r.cts_q && !st_r.brk_q;
  endsequence

  property p_rts_off;
    @(posedge ref_clk) disable iff (rst)
      (mode == MTC_MODE_OFF && !ext_rts_select) |=> !rts_out;
  endproperty
  a_rts_off: assert property (p_rts_off) else $error("rts high with no mode selected");

  property p_rts_fdx;
    @(posedge ref_clk) disable iff (rst)
      (mode == MTC_MODE_FDX && !ext_rts_select) |=> rts_out;
  endproperty
  a_rts_fdx: assert property (p_rts_fdx) else $error("rts low in full duplex modem mode");

  property p_start_gated;
    @(posedge ref_clk) disable iff (rst)
      $rose(tx_start) |-> $past(st_r.cts_q) && $past(rts_out);
  endproperty
  a_start_gated: assert property (p_start_gated) else $error("character started without rts and cts");

  property p_ignore_window;
    @(posedge ref_clk) disable iff (rst)
      s_rts_edge |-> cmd_ignoring [*8];
  endproperty
  a_ignore_window: assert property (p_ignore_window) else $error("no ignore window after rts edge");

  property p_ignored_code;
    @(posedge ref_clk) disable iff (rst)
      (cmd_ignoring && rx_take && extension_gate_select) |=> $stable(ext_enabled);
  endproperty
  a_ignored_code: assert property (p_ignored_code) else $error("code acted on during ignore window");

  property p_gate_off;
    @(posedge ref_clk) disable iff (rst)
      (extension_gate_select && cmd_ok && rx_data == `MTC_CODE_CTRLO) |=> !ext_enabled;
  endproperty
  a_gate_off: assert property (p_gate_off) else $error("ctrl-o did not gate extension port");

  property p_sec_clear;
    @(posedge ref_clk) disable iff (rst)
      (mode == MTC_MODE_SEC && !ext_rts_select && !st_r.sec_q && st_r.dcd_q) |=> !rts_out ##1 !tx_start;
  endproperty
  a_sec_clear: assert property (p_sec_clear) else $error("rts not cleared on secondary receive low");

  property p_sec_grant;
    @(posedge ref_clk) disable iff (rst)
      (mode == MTC_MODE_SEC && !rts_out) |-> sec_xmit_out;
  endproperty
  a_sec_grant: assert property (p_sec_grant) else $error("secondary transmit not granted");

  property p_break;
    @(posedge ref_clk) disable iff (rst)
      st_r.brk_q |=> txd_force_space && !tx_start;
  endproperty
  a_break: assert property (p_break) else $error("break did not force spacing");

  property p_direct_rts;
    @(posedge ref_clk) disable iff (rst)
      ((mode == MTC_MODE_DIRECT && !ext_rts_select && st_r.pend) and s_start_ok) |=> rts_out;
  endproperty
  a_direct_rts: assert property (p_direct_rts) else $error("rts dropped before direct character");

  property p_forward;
    @(posedge ref_clk) disable iff (rst)
      (rx_take && ext_enabled) |=> ext_valid;
  endproperty
  a_forward: assert property (p_forward) else $error("received byte not forwarded");

  property p_code_drop;
    @(posedge ref_clk) disable iff (rst)
      (mode == MTC_MODE_CODE && !ext_rts_select && rts_out && cmd_ok && is_turn_code) |=> !rts_out;
  endproperty
  a_code_drop: assert property (p_code_drop) else $error("turnaround code did not drop rts");

  property p_kb_lock;
    @(posedge ref_clk) disable iff (rst)
      (!extension_gate_select && cmd_ok && rx_data == `MTC_CODE_CTRLO) |=> keyboard_locked && ext_enabled;
  endproperty
  a_kb_lock: assert property (p_kb_lock) else $error("ctrl-o did not lock keyboard");

  property p_echo;
    @(posedge ref_clk) disable iff (rst)
      tx_start |-> (echo_valid != $past(fdx_mode));
  endproperty
  a_echo: assert property (p_echo) else $error("local echo does not follow duplex setting");
endmodule : mtc_turnaround

// *** tb/mtc_host_model.sv ***
// host or modem model with the transmit serializer busy timing
`timescale 1ns/10ps
module mtc_host_model #(
  parameter int BUSY_CYCLES = 12
) (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // device side
  input  wire logic rts_out,
  input  wire logic tx_start,
  output logic      cts_pin,
  output logic      tx_busy
);
  int busy_cnt;
  int cts_cnt;

  // cts answers rts after a short host delay and drops with it
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cts_cnt <= 0;
    end else if (!rts_out) begin
      cts_cnt <= 0;
    end else if (cts_cnt < 4) begin
      cts_cnt <= cts_cnt + 1;
    end
  end
  assign cts_pin = (cts_cnt == 4);

  // serializer stays busy for one character after each start
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      busy_cnt <= 0;
    end else if (tx_start) begin
      busy_cnt <= BUSY_CYCLES;
    end else if (busy_cnt > 0) begin
      busy_cnt <= busy_cnt - 1;
    end
  end
  assign tx_busy = (busy_cnt != 0);
endmodule : mtc_host_model

// *** tb/tb.sv ***
// self-checking bench for the modem turnaround control block
`timescale 1ns/10ps
`include "mtc_consts.svh"
module tb import mtc_pkg::*; ;
  logic      ref_clk, rst, cts_pin, tx_busy, rts_out, sec_xmit_out, txd_force_space;
  logic      half_duplex_modem_select, full_duplex_modem_select, direct_connect_select;
  logic      turnaround_method_select, eot_turnaround_enable, etx_turnaround_enable;
  logic      extension_gate_select, ext_rts_select, fdx_mode, dcd_pin, sec_rcve_pin, ext_rts_pin;
  logic      break_key, repeat_key, key_valid, key_ready, keyboard_locked, echo_valid, tx_start;
  logic      rx_valid, rx_ready, cmd_ignoring, ext_valid, ext_ready, ext_enabled;
  mtc_byte_t key_data, echo_data, tx_data, rx_data, ext_data, b;
  mtc_byte_t q[$];
  logic [31:0] seed;
  int        error_cnt, checks, cycles, i, n;

  localparam int REP_CYC = 50;

  // device under test with short counts
  mtc_turnaround #(.IGNORE_CYCLES(20), .REPEAT_CYCLES(REP_CYC)) DUT (
    .ref_clk, .rst, .half_duplex_modem_select, .full_duplex_modem_select, .direct_connect_select,
    .turnaround_method_select, .eot_turnaround_enable, .etx_turnaround_enable, .extension_gate_select,
    .ext_rts_select, .fdx_mode, .cts_pin, .dcd_pin, .sec_rcve_pin, .ext_rts_pin, .rts_out, .sec_xmit_out,
    .txd_force_space, .break_key, .repeat_key, .key_valid, .key_ready, .key_data, .keyboard_locked,
    .echo_valid, .echo_data, .tx_start, .tx_data, .tx_busy, .rx_valid, .rx_ready, .rx_data,
    .cmd_ignoring, .ext_valid, .ext_ready, .ext_data, .ext_enabled);

  // far side model
  mtc_host_model HOST (.ref_clk, .rst, .rts_out, .tx_start, .cts_pin, .tx_busy);

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      error_cnt++;
    end
  endtask : chk

  task automatic chkb(input logic got, input logic exp);
    chk({7'h00, got}, {7'h00, exp});
  endtask : chkb

  task automatic clk(input int k);
    repeat (k) @(posedge ref_clk);
  endtask : clk

  task automatic wait_rts(input logic v);
    for (n = 0; n < 40 && rts_out !== v; n++) @(posedge ref_clk);
  endtask : wait_rts

  task automatic quiet();
    for (n = 0; n < 60 && cmd_ignoring !== 1'b0; n++) @(posedge ref_clk);
  endtask : quiet

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask : done

  // one received byte, held until taken
  task automatic rx_send(input mtc_byte_t d);
    rx_valid <= 1'b1;
    rx_data  <= d;
    @(posedge ref_clk);
    while (rx_ready !== 1'b1) @(posedge ref_clk);
    rx_valid <= 1'b0;
    @(posedge ref_clk);
  endtask : rx_send

  // one key, then the transmit start that it causes
  task automatic key_send(input mtc_byte_t d);
    key_valid <= 1'b1;
    key_data  <= d;
    @(posedge ref_clk);
    while (key_ready !== 1'b1) @(posedge ref_clk);
    key_valid <= 1'b0;
    for (n = 0; n < 60 && tx_start !== 1'b1; n++) @(posedge ref_clk);
    chk(tx_data, d);
    chkb(echo_valid, !fdx_mode);
    if (!fdx_mode) chk(echo_data, d);
    chkb(cts_pin, 1'b1);
    chkb(rts_out, 1'b1);
  endtask : key_send

  task automatic end_of_test();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test

  // clock
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      end_of_test();
    end
  end

  // main sequence
  initial begin
    {half_duplex_modem_select, full_duplex_modem_select, direct_connect_select, turnaround_method_select,
     eot_turnaround_enable, etx_turnaround_enable, extension_gate_select, ext_rts_select, fdx_mode,
     sec_rcve_pin, ext_rts_pin, break_key, repeat_key, key_valid, rx_valid} = '0;
    {key_data, rx_data} = '0;
    dcd_pin = 1'b1;
    ext_ready = 1'b1;
    seed = 32'h6245;
    rst = 1'b1;
    clk(3);
    rst <= 1'b0;
    clk(6);
    chkb(rts_out, 1'b0);
    ext_rts_select <= 1'b1;
    ext_rts_pin <= 1'b1;
    wait_rts(1'b1);
    chkb(rts_out, 1'b1);
    ext_rts_pin <= 1'b0;
    wait_rts(1'b0);
    chkb(rts_out, 1'b0);
    ext_rts_select <= 1'b0;
    quiet();
    done("off");
    direct_connect_select <= 1'b1;
    clk(4);
    chkb(rts_out, 1'b0);
    for (i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      key_send(seed[7:0]);
      wait_rts(1'b0);
      chkb(rts_out, 1'b0);
      clk(2);
      chkb(cmd_ignoring, 1'b1);
      quiet();
    end
    break_key <= 1'b1;
    clk(8);
    chkb(txd_force_space, 1'b1);
    break_key <= 1'b0;
    clk(8);
    chkb(txd_force_space, 1'b0);
    done("direct");
    direct_connect_select <= 1'b0;
    full_duplex_modem_select <= 1'b1;
    fdx_mode <= 1'b1;
    wait_rts(1'b1);
    chkb(rts_out, 1'b1);
    quiet();
    key_send(8'h41);
    full_duplex_modem_select <= 1'b0;
    fdx_mode <= 1'b0;
    wait_rts(1'b0);
    rx_send(`MTC_CODE_CTRLO);
    clk(2);
    chkb(cmd_ignoring, 1'b1);
    chkb(keyboard_locked, 1'b0);
    quiet();
    rx_send(`MTC_CODE_CTRLO);
    clk(2);
    chkb(keyboard_locked, 1'b1);
    chkb(key_ready, 1'b0);
    chkb(ext_enabled, 1'b1);
    rx_send(`MTC_CODE_CTRLN);
    clk(2);
    chkb(keyboard_locked, 1'b0);
    done("lock");
    extension_gate_select <= 1'b1;
    seed = lfsr(seed);
    b = seed[7:0] | 8'h80;
    rx_send(b);
    for (n = 0; n < 10 && ext_valid !== 1'b1; n++) @(posedge ref_clk);
    chk(ext_data, b);
    rx_send(`MTC_CODE_CTRLO);
    clk(6);
    chkb(ext_enabled, 1'b0);
    rx_send(b);
    clk(3);
    chkb(ext_valid, 1'b0);
    rx_send(`MTC_CODE_CTRLN);
    clk(6);
    chkb(ext_enabled, 1'b1);
    ext_ready <= 1'b0;
    for (i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      b = seed[7:0] | 8'h80;
      q.push_back(b);
      rx_send(b);
    end
    clk(2);
    chkb(rx_ready, 1'b0);
    ext_ready <= 1'b1;
    while (q.size() > 0) begin
      @(posedge ref_clk);
      if (ext_valid === 1'b1) chk(ext_data, q.pop_front());
    end
    done("gate");
    half_duplex_modem_select <= 1'b1;
    sec_rcve_pin <= 1'b1;
    clk(8);
    chkb(sec_xmit_out, 1'b1);
    chkb(rts_out, 1'b0);
    dcd_pin <= 1'b0;
    wait_rts(1'b1);
    chkb(rts_out, 1'b1);
    chkb(sec_xmit_out, 1'b0);
    quiet();
    seed = lfsr(seed);
    key_send(seed[7:0]);
    dcd_pin <= 1'b1;
    sec_rcve_pin <= 1'b0;
    wait_rts(1'b0);
    chkb(rts_out, 1'b0);
    done("secondary");
    for (i = 0; i < 2; i++) begin
      turnaround_method_select <= 1'b1;
      eot_turnaround_enable <= (i == 0);
      etx_turnaround_enable <= (i == 1);
      clk(8);
      quiet();
      dcd_pin <= 1'b0;
      wait_rts(1'b1);
      chkb(rts_out, 1'b1);
      quiet();
      seed = lfsr(seed);
      key_send(seed[7:0]);
      rx_send(i ? `MTC_CODE_ETX : `MTC_CODE_EOT);
      wait_rts(1'b0);
      chkb(rts_out, 1'b0);
      clk(2);
      chkb(cmd_ignoring, 1'b1);
      rx_send(`MTC_CODE_CTRLO);
      chkb(ext_enabled, 1'b1);
      dcd_pin <= 1'b1;
      quiet();
    end
    done("code");
    half_duplex_modem_select <= 1'b0;
    full_duplex_modem_select <= 1'b1;
    fdx_mode <= 1'b1;
    wait_rts(1'b1);
    quiet();
    seed = lfsr(seed);
    b = seed[7:0];
    key_send(b);
    repeat_key <= 1'b1;
    for (i = 0; i < 2; i++) begin
      @(posedge ref_clk);
      for (n = 1; n < 4 * REP_CYC && tx_start !== 1'b1; n++) @(posedge ref_clk);
      chk(tx_data, b);
      chkb(n >= REP_CYC && n <= REP_CYC + 2, 1'b1);
    end
    repeat_key <= 1'b0;
    done("repeat");
    end_of_test();
  end
endmodule : tb
